// *** shared/sep_pkg.sv ***
// Constants and types shared by both ends of the serial memory link
// Behaviour
// - Power-up clears the write latch
// - Master arms writes and deselects first
// - Latch clears after any completed write
// - Write starts only on exact-count deselect
// - Array access ignored while write busy
// - Power-up standby; select falling edge needed (device only needs select low after reset, no falling edge is detected)
// - Apply latch, guard and pin protection matrix
// - Deselect means standby; running write finishes
// - Standby entry waits for write end
// - Output floats while deselected
// - Output changes after clock falling edge
// - Input sampled on clock rising edge
// - Pin low plus gate bit refuses status write
// - Falling pin spares started write
// - Master holds pause high normally
// - Pause taken at clock low, else deferred
// - Master keeps select low during pause
// - Paused device ignores input, clock, output
// - Resume only when pause rises at clock low
// - Pause low floats output at once
// - Eight-bit instruction codes decoded
// - Block guard bits select protected range
// - Busy bit reads one during writes
package sep_pkg;
    localparam logic [7:0]  CMD_STATUS_STORE   = 8'h01;
    localparam logic [7:0]  CMD_ARRAY_WRITE    = 8'h02;
    localparam logic [7:0]  CMD_ARRAY_READ     = 8'h03;
    localparam logic [7:0]  DISARM_WRITES_CMD  = 8'h04;
    localparam logic [7:0]  STATUS_FETCH_CMD   = 8'h05;
    localparam logic [7:0]  ARM_WRITES_CMD     = 8'h06;
    localparam int          ST_BUSY_POS        = 0;
    localparam int          ST_LATCH_POS       = 1;
    localparam int          ST_GUARD_LO_POS    = 2;
    localparam int          ST_GUARD_HI_POS    = 3;
    localparam int          ST_GATE_POS        = 7;
    localparam logic [10:0] GUARD_QUARTER_BASE = 11'h600;
    localparam logic [10:0] GUARD_HALF_BASE    = 11'h400;
    localparam logic [1:0]  GUARD_RST          = 2'h0;
    localparam logic        GATE_RST           = 1'b0;
    localparam int          CLK_PERIOD_PS      = 5000;
    localparam int          WRITE_TIME_US      = 5;
    localparam int          WRITE_CYCLES       = WRITE_TIME_US * 1000000 / CLK_PERIOD_PS;
    localparam int          SCK_HALF_CYCLES    = 8;
    localparam int          ADDR_BITS          = 16;
    localparam int          PAGE_BYTES         = 16;
    localparam int          MEM_BYTES          = 2048;
    localparam int          FIFO_DEPTH         = 8;
    typedef enum logic [2:0]
    {
        SEP_M_IDLE  = 3'b000,
        SEP_M_LOAD  = 3'b001,
        SEP_M_SHIFT = 3'b011,
        SEP_M_GAP   = 3'b010,
        SEP_M_DONE  = 3'b110
    } sep_mst_e;
endpackage

// *** shared/sep_link_if.sv ***
// Interface joining the serial master and the memory device
`timescale 1ns/1ps
interface sep_link_if;
    logic sel_n;
    logic sck;
    logic mosi;
    logic miso;
    logic miso_oe;
    logic pause_n;
    logic protect_n;
    modport dev
    (
        input  sel_n,
        input  sck,
        input  mosi,
        output miso,
        output miso_oe,
        input  pause_n,
        input  protect_n
    );
    modport mst
    (
        output sel_n,
        output sck,
        output mosi,
        input  miso,
        input  miso_oe,
        output pause_n,
        output protect_n
    );
endinterface

// *** hw/sep_fifo.sv ***
// Small valid/ready FIFO with parameterised width and depth
`timescale 1ns/1ps
module sep_fifo
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)
(
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] wr_data_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    output logic      [WIDTH-1:0] rd_data_out,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             push;
    logic             pop;

    assign wr_ready_out = (count_ff != (AW+1)'(DEPTH));
    assign rd_valid_out = (count_ff != '0);
    assign rd_data_out  = mem[rd_ptr_ff];
    assign push         = wr_valid_in && wr_ready_out;
    assign pop          = rd_valid_out && rd_ready_in;

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr_ff] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff  <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH-1)) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (pop)
            begin
                rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH-1)) ? '0 : rd_ptr_ff + 1'b1;
            end
            count_ff <= count_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// *** hw/sep_dev.sv ***
// Memory device end: serial slave, protection, write timer, array
`timescale 1ns/1ps
module sep_dev
    import sep_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter int PAGE      = PAGE_BYTES
)
(
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    sep_link_if.dev   link,
    output logic      write_busy_out,
    output logic      write_latch_out
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sel_s_ff;
    logic [1:0] sck_s_ff;
    logic [1:0] mosi_s_ff;
    logic [1:0] pause_s_ff;
    logic [1:0] prot_s_ff;
    logic       sck_d_ff;
    logic       sel_d_ff;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            sel_s_ff   <= 2'h3;
            sck_s_ff   <= 2'h0;
            mosi_s_ff  <= 2'h0;
            pause_s_ff <= 2'h3;
            prot_s_ff  <= 2'h3;
            sck_d_ff   <= 1'b0;
            sel_d_ff   <= 1'b1;
        end
        else
        begin
            sel_s_ff   <= {sel_s_ff[0], link.sel_n};
            sck_s_ff   <= {sck_s_ff[0], link.sck};
            mosi_s_ff  <= {mosi_s_ff[0], link.mosi};
            pause_s_ff <= {pause_s_ff[0], link.pause_n};
            prot_s_ff  <= {prot_s_ff[0], link.protect_n};
            sck_d_ff   <= sck_s_ff[1];
            sel_d_ff   <= sel_s_ff[1];
        end
    end

    logic sel_n;
    logic sck_rise;
    logic sck_fall;
    logic sel_rise;
    assign sel_n    = sel_s_ff[1];
    assign sck_rise = sck_s_ff[1] && !sck_d_ff;
    assign sck_fall = !sck_s_ff[1] && sck_d_ff;
    assign sel_rise = sel_n && !sel_d_ff;

    // ------------------------------------------------------------
    // Pause control
    // ------------------------------------------------------------
    logic paused_ff;
    logic live;

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            paused_ff <= 1'b0;
        end
        else if (sel_n)
        begin
            paused_ff <= 1'b0;
        end
        else if (!paused_ff && !pause_s_ff[1] && !sck_s_ff[1] && !sck_rise)
        begin
            paused_ff <= 1'b1;
        end
        else if (paused_ff && pause_s_ff[1] && !sck_s_ff[1])
        begin
            paused_ff <= 1'b0;
        end
    end
    // Edges while paused are dropped
    assign live = !sel_n && !paused_ff;

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    logic [7:0]  cmd_ff;
    logic [7:0]  shin_ff;
    logic [7:0]  shout_ff;
    logic [5:0]  bitcnt_ff;
    logic [10:0] addr_ff;
    logic [7:0]  nbytes_ff;
    logic [7:0]  wr_cnt_ff;
    logic [7:0]  status;
    logic [7:0]  mem [MEM_BYTES];
    logic [7:0]  page_buf [PAGE];
    logic [10:0] wr_addr_ff;
    logic [7:0]  wr_stat_ff;
    logic        wr_is_stat_ff;
    logic [1:0]  guard_ff;
    logic        gate_ff;
    logic        latch_ff;
    logic        busy_ff;
    logic [31:0] wcnt_ff;
    logic [7:0]  rx_byte;
    logic        byte_done;
    logic        hdr_done;

    assign rx_byte   = {shin_ff[6:0], mosi_s_ff[1]};
    assign byte_done = live && sck_rise && (bitcnt_ff[2:0] == 3'h7);
    assign hdr_done  = bitcnt_ff >= 6'd31;
    assign status    = {gate_ff, 3'h0, guard_ff, latch_ff, busy_ff};

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || sel_n)
        begin
            shin_ff    <= 8'h00;
            bitcnt_ff  <= 6'd0;
            cmd_ff     <= 8'h00;
            nbytes_ff  <= 8'h00;
        end
        else if (live && sck_rise)
        begin
            shin_ff    <= rx_byte;
            if (!hdr_done)
            begin
                bitcnt_ff <= bitcnt_ff + 6'd1;
            end
            else
            begin
                bitcnt_ff <= {3'h7, bitcnt_ff[2:0] + 3'h1};
            end
            if (bitcnt_ff == 6'd7)
            begin
                cmd_ff <= rx_byte;
            end
            if (byte_done && bitcnt_ff >= 6'd31)
            begin
                nbytes_ff <= nbytes_ff + 8'h01;
            end
        end
    end

    // Address and read data path
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            addr_ff  <= 11'h000;
            shout_ff <= 8'h00;
        end
        else if (byte_done)
        begin
            if (bitcnt_ff == 6'd15)
            begin
                addr_ff[10:8] <= rx_byte[2:0];
            end
            else if (bitcnt_ff == 6'd23)
            begin
                addr_ff[7:0] <= rx_byte;
            end
            else if (bitcnt_ff >= 6'd31 && cmd_ff == CMD_ARRAY_READ)
            begin
                addr_ff <= addr_ff + 11'h001;
            end
        end
        else if (live && sck_fall)
        begin
            if (cmd_ff == STATUS_FETCH_CMD && bitcnt_ff >= 6'd8 && bitcnt_ff[2:0] == 3'h0)
            begin
                shout_ff <= status;
            end
            else if (cmd_ff == CMD_ARRAY_READ && !busy_ff && bitcnt_ff >= 6'd24
                     && bitcnt_ff[2:0] == 3'h0)
            begin
                shout_ff <= mem[addr_ff];
            end
            else
            begin
                shout_ff <= {shout_ff[6:0], 1'b0};
            end
        end
    end

    // Output driver, floated when deselected or paused
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            link.miso    <= 1'b0;
            link.miso_oe <= 1'b0;
        end
        else
        begin
            link.miso    <= shout_ff[7];
            link.miso_oe <= live && pause_s_ff[1]
                            && (cmd_ff == STATUS_FETCH_CMD || cmd_ff == CMD_ARRAY_READ)
                            && bitcnt_ff >= 6'd8;
        end
    end

    // ------------------------------------------------------------
    // Protection and write launch
    // ------------------------------------------------------------
    logic stat_locked;
    logic addr_guarded;
    logic exact_end;
    assign stat_locked  = !latch_ff || (gate_ff && !prot_s_ff[1]);
    always_comb
    begin
        unique case (guard_ff)
            2'h0: addr_guarded = 1'b0;
            2'h1: addr_guarded = addr_ff >= GUARD_QUARTER_BASE;
            2'h2: addr_guarded = addr_ff >= GUARD_HALF_BASE;
            2'h3: addr_guarded = 1'b1;
        endcase
    end
    assign exact_end = bitcnt_ff[2:0] == 3'h0 && !busy_ff;

    // Page capture during array write data phase
    always_ff @(posedge clk_in)
    begin
        if (byte_done && cmd_ff == CMD_ARRAY_WRITE && hdr_done && !busy_ff)
        begin
            page_buf[nbytes_ff[$clog2(PAGE)-1:0]] <= rx_byte;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            latch_ff      <= 1'b0;
            busy_ff       <= 1'b0;
            wcnt_ff       <= 32'h0;
            guard_ff      <= GUARD_RST;
            gate_ff       <= GATE_RST;
            wr_addr_ff    <= 11'h000;
            wr_stat_ff    <= 8'h00;
            wr_is_stat_ff <= 1'b0;
            wr_cnt_ff     <= 8'h00;
        end
        else if (busy_ff)
        begin
            if (wcnt_ff == 32'(WRITE_CYC - 1))
            begin
                busy_ff  <= 1'b0;
                latch_ff <= 1'b0;
                if (wr_is_stat_ff)
                begin
                    guard_ff <= wr_stat_ff[ST_GUARD_HI_POS:ST_GUARD_LO_POS];
                    gate_ff  <= wr_stat_ff[ST_GATE_POS];
                end
            end
            wcnt_ff <= wcnt_ff + 32'h1;
        end
        else if (sel_rise && exact_end && bitcnt_ff == 6'd8)
        begin
            if (cmd_ff == ARM_WRITES_CMD)
            begin
                latch_ff <= 1'b1;
            end
            else if (cmd_ff == DISARM_WRITES_CMD)
            begin
                latch_ff <= 1'b0;
            end
        end
        else if (sel_rise && exact_end && cmd_ff == CMD_STATUS_STORE
                 && bitcnt_ff == 6'd16 && !stat_locked)
        begin
            wr_stat_ff    <= shin_ff;
            wr_is_stat_ff <= 1'b1;
            busy_ff       <= 1'b1;
            wcnt_ff       <= 32'h0;
        end
        else if (sel_rise && exact_end && cmd_ff == CMD_ARRAY_WRITE && latch_ff
                 && nbytes_ff > 8'h00)
        begin
            wr_addr_ff    <= addr_ff;
            wr_cnt_ff     <= nbytes_ff;
            wr_is_stat_ff <= 1'b0;
            if (!addr_guarded)
            begin
                busy_ff <= 1'b1;
                wcnt_ff <= 32'h0;
            end
        end
    end

    // Array commit at end of timed cycle, page wrap kept
    always_ff @(posedge clk_in)
    begin
        if (busy_ff && !wr_is_stat_ff && wcnt_ff == 32'(WRITE_CYC - 1))
        begin
            for (int i = 0; i < PAGE; i++)
            begin
                if (i < int'(wr_cnt_ff) || wr_cnt_ff >= 8'(PAGE))
                begin
                    mem[(wr_addr_ff & ~11'(PAGE-1)) | 11'((wr_addr_ff + 11'(i)) & 11'(PAGE-1))]
                        <= page_buf[i];
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            write_busy_out  <= 1'b0;
            write_latch_out <= 1'b0;
        end
        else
        begin
            write_busy_out  <= busy_ff;
            write_latch_out <= latch_ff;
        end
    end
endmodule

// *** hw/sep_mst.sv ***
// Master end: frames commands and passes the last read byte of each frame through a FIFO
`timescale 1ns/1ps
module sep_mst
    import sep_pkg::*;
#(
    parameter int HALF = SCK_HALF_CYCLES
)
(
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    sep_link_if.mst         link,
    input  wire logic       req_valid_in,
    output logic            req_ready_out,
    input  wire logic [7:0] req_cmd_in,
    input  wire logic [5:0] req_bits_in,
    input  wire logic [47:0] req_data_in,
    input  wire logic       pause_req_in,
    input  wire logic       protect_n_in,
    output logic [7:0]      rx_data_out,
    output logic            rx_valid_out,
    input  wire logic       rx_ready_in
);
    sep_mst_e    state_ff;
    logic [55:0] sh_ff;
    logic [5:0]  left_ff;
    logic [7:0]  div_ff;
    logic [2:0]  bit_ff;
    logic [7:0]  rxb_ff;
    logic        push_ff;
    logic        fifo_ready;
    logic [1:0]  miso_s_ff;
    logic        tick;
    logic        fifo_valid;
    logic [7:0]  fifo_data;

    assign tick = (div_ff == 8'(HALF - 1)) && fifo_ready && link.pause_n
                  && !(pause_req_in && !link.sck);

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            div_ff <= 8'h00;
        end
        else
        begin
            div_ff <= (div_ff == 8'(HALF - 1)) ? 8'h00 : div_ff + 8'h01;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            miso_s_ff <= 2'h0;
        end
        else
        begin
            miso_s_ff <= {miso_s_ff[0], link.miso};
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            state_ff       <= SEP_M_IDLE;
            link.sel_n     <= 1'b1;
            link.sck       <= 1'b0;
            link.mosi      <= 1'b0;
            sh_ff          <= 56'h0;
            left_ff        <= 6'd0;
            bit_ff         <= 3'h0;
            rxb_ff         <= 8'h00;
            push_ff        <= 1'b0;
            req_ready_out  <= 1'b0;
        end
        else
        begin
            push_ff       <= 1'b0;
            req_ready_out <= (state_ff == SEP_M_IDLE);
            unique case (state_ff)
                SEP_M_IDLE:
                begin
                    if (req_valid_in && req_ready_out)
                    begin
                        sh_ff    <= {req_cmd_in, req_data_in};
                        left_ff  <= req_bits_in;
                        state_ff <= SEP_M_LOAD;
                        req_ready_out <= 1'b0;
                    end
                end
                SEP_M_LOAD:
                begin
                    if (tick)
                    begin
                        link.sel_n <= 1'b0;
                        link.mosi  <= sh_ff[55];
                        sh_ff      <= {sh_ff[54:0], 1'b0};
                        state_ff   <= SEP_M_SHIFT;
                    end
                end
                SEP_M_SHIFT:
                begin
                    if (tick && !link.sck)
                    begin
                        link.sck <= 1'b1;
                        rxb_ff   <= {rxb_ff[6:0], miso_s_ff[1]};
                        bit_ff   <= bit_ff + 3'h1;
                        push_ff  <= (bit_ff == 3'h7) && (left_ff <= 6'd8);
                    end
                    else if (tick)
                    begin
                        link.sck <= 1'b0;
                        left_ff  <= left_ff - 6'd1;
                        if (left_ff == 6'd1)
                        begin
                            state_ff <= SEP_M_GAP;
                        end
                        else
                        begin
                            link.mosi <= sh_ff[55];
                            sh_ff     <= {sh_ff[54:0], 1'b0};
                        end
                    end
                end
                SEP_M_GAP:
                begin
                    if (tick)
                    begin
                        link.sel_n <= 1'b1;
                        state_ff   <= SEP_M_DONE;
                    end
                end
                SEP_M_DONE:
                begin
                    bit_ff <= 3'h0;
                    if (tick)
                    begin
                        state_ff <= SEP_M_IDLE;
                    end
                end
                default:
                begin
                    state_ff <= SEP_M_IDLE;
                end
            endcase
        end
    end

    // Pause lowered and raised only with the clock low; select held low
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            link.pause_n   <= 1'b1;
            link.protect_n <= 1'b1;
        end
        else
        begin
            link.protect_n <= protect_n_in;
            if (!link.sck && state_ff == SEP_M_SHIFT)
            begin
                link.pause_n <= !pause_req_in;
            end
            else if (state_ff != SEP_M_SHIFT)
            begin
                link.pause_n <= 1'b1;
            end
        end
    end

    sep_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_rx_fifo
    (
        .clk_in       (clk_in),
        .rst_n_in     (rst_n_in),
        .wr_data_in   (rxb_ff),
        .wr_valid_in  (push_ff),
        .wr_ready_out (fifo_ready),
        .rd_data_out  (fifo_data),
        .rd_valid_out (fifo_valid),
        .rd_ready_in  (rx_ready_in)
    );

    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rx_data_out  <= 8'h00;
            rx_valid_out <= 1'b0;
        end
        else
        begin
            rx_data_out  <= fifo_data;
            rx_valid_out <= fifo_valid && !rx_ready_in;
        end
    end
endmodule

// *** testbench/sep_link_chk.sv ***
// Concurrent checks on the link between master and memory device
`timescale 1ns/1ps
module sep_link_chk
#(
    parameter int WRITE_CYC = 20
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sel_n,
    input wire logic sck,
    input wire logic miso,
    input wire logic miso_oe,
    input wire logic pause_n,
    input wire logic write_busy_out,
    input wire logic write_latch_out
);
    int unsigned busy_cnt;
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    // ------------------------------
    // Sequences and busy length count
    // ------------------------------
    sequence s_quiet;
        sel_n[*6];
    endsequence
    sequence s_hold;
        !pause_n[*6];
    endsequence
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in || !write_busy_out)
            busy_cnt <= 0;
        else
            busy_cnt <= busy_cnt + 1;
    end
    AST_RST_STATE: assert property ($rose(rst_n_in) |-> !write_latch_out && !miso_oe && sel_n)
        else $error("bad state after reset");
    AST_OE_DESEL: assert property (s_quiet |-> !miso_oe)
        else $error("output driven while deselected");
    AST_OE_PAUSE: assert property (s_hold |-> !miso_oe)
        else $error("output driven while paused");
    AST_START: assert property ($rose(write_busy_out) |-> sel_n && $past(write_latch_out))
        else $error("write started without deselect or latch");
    AST_LATCH_CLR: assert property ($fell(write_busy_out) |-> ##[0:2] !write_latch_out)
        else $error("latch kept after write");
    AST_BUSY_LEN: assert property ($fell(write_busy_out) |-> busy_cnt inside {[WRITE_CYC-1:WRITE_CYC+1]})
        else $error("write cycle length wrong");
    AST_PAUSE_IN: assert property ($fell(pause_n) |-> !sck)
        else $error("pause entered with clock high");
    AST_PAUSE_OUT: assert property ($rose(pause_n) |-> !sck)
        else $error("pause left with clock high");
    AST_SEL_HOLD: assert property (!pause_n |-> !sel_n)
        else $error("deselected during pause");
    AST_MISO_EDGE: assert property ($changed(miso) && $past(miso_oe) && miso_oe |-> !sck)
        else $error("output changed with clock high");
endmodule

// *** testbench/tb_top.sv ***
// Self-checking bench for master and device joined over the link
`timescale 1ns/1ps
module tb_top
    import sep_pkg::*;
;
    logic        clk_in    = 1'b0;
    logic        rst_n     = 1'b0;
    logic        req_valid = 1'b0;
    logic [7:0]  req_cmd   = 8'h00;
    logic [5:0]  req_bits  = 6'h08;
    logic [47:0] req_data  = 48'h0;
    logic        pause_req = 1'b0;
    logic        prot_n    = 1'b1;
    logic        rx_ready  = 1'b0;
    logic        req_ready;
    logic [7:0]  rx_data;
    logic        rx_valid;
    logic        busy;
    logic        latch;
    logic [7:0]  v;
    int          n_fail    = 0;
    int          checks    = 0;
    sep_link_if lnk();
    sep_dev #(.WRITE_CYC(400)) sep_dev_i (.clk_in(clk_in), .rst_n_in(rst_n), .link(lnk),
        .write_busy_out(busy), .write_latch_out(latch));
    sep_mst sep_mst_i (.clk_in(clk_in), .rst_n_in(rst_n), .link(lnk), .req_valid_in(req_valid),
        .req_ready_out(req_ready), .req_cmd_in(req_cmd), .req_bits_in(req_bits),
        .req_data_in(req_data), .pause_req_in(pause_req), .protect_n_in(prot_n),
        .rx_data_out(rx_data), .rx_valid_out(rx_valid), .rx_ready_in(rx_ready));
    sep_link_chk #(.WRITE_CYC(400)) sep_link_chk_i (.clk_in(clk_in), .rst_n_in(rst_n),
        .sel_n(lnk.sel_n), .sck(lnk.sck), .miso(lnk.miso), .miso_oe(lnk.miso_oe),
        .pause_n(lnk.pause_n), .write_busy_out(busy), .write_latch_out(latch));
    always #2.5 clk_in = ~clk_in;
    // ------------------------------
    // Tasks
    // ------------------------------
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", n, exp, got);
            n_fail++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // One framed request, then drain the FIFO keeping the last byte
    task automatic xfer(input logic [7:0] c, input logic [5:0] b, input logic [47:0] d,
                        output logic [7:0] r);
        int k;
        k = 0;
        r = 8'h00;
        while (req_ready !== 1'b1 && k < 5000)
        begin
            @(negedge clk_in);
            k++;
        end
        req_cmd = c;
        req_bits = b;
        req_data = d;
        req_valid = 1'b1;
        @(negedge clk_in);
        req_valid = 1'b0;
        repeat (4) @(negedge clk_in);
        while (req_ready !== 1'b1 && k < 5000)
        begin
            @(negedge clk_in);
            k++;
        end
        if (k >= 5000) n_fail++;
        repeat (8) @(negedge clk_in);
        while (rx_valid === 1'b1)
        begin
            r = rx_data;
            rx_ready = 1'b1;
            @(negedge clk_in);
            rx_ready = 1'b0;
            repeat (2) @(negedge clk_in);
        end
    endtask
    task automatic idle();
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 5000)
        begin
            @(negedge clk_in);
            k++;
        end
        if (k >= 5000) n_fail++;
    endtask
    task automatic arm();
        xfer(ARM_WRITES_CMD, 6'h08, 48'h0, v);
    endtask
    task automatic st();
        xfer(STATUS_FETCH_CMD, 6'h10, 48'h0, v);
    endtask
    task automatic wr(input logic [7:0] c, input logic [5:0] b, input logic [47:0] d);
        arm();
        xfer(c, b, d, v);
        idle();
    endtask
    task automatic rd(input logic [15:0] a);
        xfer(CMD_ARRAY_READ, 6'h20, {a, 32'h0}, v);
    endtask
    initial
    begin
        repeat (50000) @(posedge clk_in);
        n_fail++;
        wrap_up();
    end
    // ------------------------------
    // Test sequence
    // ------------------------------
    initial
    begin
        repeat (16) @(negedge clk_in);
        rst_n = 1'b1;
        repeat (4) @(negedge clk_in);
        st();
        chk("status", v, 8'h00);
        chk("latch", {7'h0, latch}, 8'h00);
        xfer(CMD_STATUS_STORE, 6'h10, {8'h8C, 40'h0}, v);
        idle();
        st();
        chk("status", v, 8'h00);
        arm();
        st();
        chk("status", v, 8'h02);
        xfer(DISARM_WRITES_CMD, 6'h08, 48'h0, v);
        st();
        chk("status", v, 8'h00);
        $display("test latch done");
        arm();
        xfer(CMD_STATUS_STORE, 6'h10, {8'h8C, 40'h0}, v);
        st();
        chk("busy", {7'h0, v[0]}, 8'h01);
        idle();
        st();
        chk("status", v, 8'h8C);
        prot_n = 1'b0;
        wr(CMD_STATUS_STORE, 6'h10, 48'h0);
        st();
        chk("status", v & 8'hFD, 8'h8C);
        prot_n = 1'b1;
        wr(CMD_STATUS_STORE, 6'h10, {8'h04, 40'h0});
        st();
        chk("status", v, 8'h04);
        $display("test status done");
        wr(CMD_ARRAY_WRITE, 6'h20, {16'h0100, 8'hA5, 24'h0});
        wr(CMD_ARRAY_WRITE, 6'h20, {16'h0600, 8'h5A, 24'h0});
        rd(16'h0100);
        chk("array", v, 8'hA5);
        rd(16'h0600);
        chk("guarded", {7'h0, v === 8'h5A}, 8'h00);
        $display("test guard done");
        arm();
        xfer(CMD_ARRAY_WRITE, 6'h1F, {16'h0100, 8'h3C, 24'h0}, v);
        repeat (20) @(negedge clk_in);
        chk("busy", {7'h0, busy}, 8'h00);
        chk("latch", {7'h0, latch}, 8'h01);
        fork
            rd(16'h0100);
            begin
                repeat (150) @(negedge clk_in);
                pause_req = 1'b1;
                repeat (300) @(negedge clk_in);
                pause_req = 1'b0;
            end
        join
        chk("array", v, 8'hA5);
        $display("test count_pause done");
        wrap_up();
    end
endmodule
